// file: src/period_timer_map.vh
`ifndef PERIOD_TIMER_MAP_VH
`define PERIOD_TIMER_MAP_VH

// Register word indices, byte address is index times four
`define REG_COUNT 3'h0
`define REG_PERIOD 3'h1
`define REG_CONTROL 3'h2
`define REG_STATUS 3'h3
`define REG_MASK 3'h4

// Control field positions
`define CTL_PRE_LSB 0
`define CTL_PRE_MSB 1
`define CTL_RUN_BIT 2
`define CTL_POST_LSB 3
`define CTL_POST_MSB 6

// Reset values
`define COUNT_RST 8'h00
`define PERIOD_RST 8'hff
`define CONTROL_RST 7'h00

// Instruction clock is the system clock divided by this
`define INSTR_DIV 4

`endif

// file: src/tick_divider.v
`timescale 1ns/1ps
// Free running divider of the system clock giving the instruction tick
module tick_divider #(
    parameter DIV = 4
) (
    input wire clk_i,
    input wire rst_i,
    output wire tick_o
);
    reg [7:0] cnt_r;

    assign tick_o = (cnt_r == DIV[7:0] - 8'h01);

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
        end else if (tick_o) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // tick_divider

// file: src/period_match_timer_8bit.v
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "period_timer_map.vh"
module period_match_timer_8bit (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire wb_err_o,
    output wire irq_o,
    output reg period_match_o
);
    reg ack_r;
    reg mapped_q;
    reg [7:0] timer_count_r;
    reg [7:0] timer_count_nxt;
    reg [7:0] timer_period_r;
    reg [6:0] timer_control_r;
    reg [5:0] pre_cnt_r;
    reg [5:0] pre_cnt_nxt;
    reg [3:0] post_cnt_r;
    reg [3:0] post_cnt_nxt;
    reg period_match_flag_r;
    reg irq_mask_r;
    reg [31:0] rd_data;
    reg pre_pulse;
    reg post_pulse;
    reg match_now;
    wire instr_tick;
    wire req;
    wire wr_ok;
    wire mapped;
    wire [2:0] word_idx;
    wire timer_run;
    wire [1:0] prescale_select;
    wire [3:0] postscale_select;

    // Prescale terminal count for a select code
    function [5:0] pre_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: pre_last = 6'h00;
                2'h1: pre_last = 6'h03;
                2'h2: pre_last = 6'h0f;
                default: pre_last = 6'h3f;
            endcase
        end
    endfunction

    tick_divider #(
        .DIV(`INSTR_DIV)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(instr_tick)
    );

    assign word_idx = wb_adr_i[4:2];
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign mapped = (word_idx <= `REG_MASK);
    assign wr_ok = req & mapped & wb_we_i & wb_sel_i[0];
    assign wb_ack_o = ack_r & mapped_q;
    assign wb_err_o = ack_r & ~mapped_q;

    assign timer_run = timer_control_r[`CTL_RUN_BIT];
    assign prescale_select = timer_control_r[`CTL_PRE_MSB:`CTL_PRE_LSB];
    assign postscale_select = timer_control_r[`CTL_POST_MSB:`CTL_POST_LSB];

    wire wr_count = wr_ok & (word_idx == `REG_COUNT);
    wire wr_period = wr_ok & (word_idx == `REG_PERIOD);
    wire wr_control = wr_ok & (word_idx == `REG_CONTROL);
    wire wr_status = wr_ok & (word_idx == `REG_STATUS);
    wire wr_mask = wr_ok & (word_idx == `REG_MASK);

    // Timer next state
    always @* begin
        timer_count_nxt = timer_count_r;
        pre_cnt_nxt = pre_cnt_r;
        post_cnt_nxt = post_cnt_r;
        pre_pulse = 1'b0;
        post_pulse = 1'b0;
        match_now = (timer_count_r == timer_period_r);
        if (timer_run && instr_tick) begin
            if (pre_cnt_r >= pre_last(prescale_select)) begin
                pre_cnt_nxt = 6'h00;
                pre_pulse = 1'b1;
            end else begin
                pre_cnt_nxt = pre_cnt_r + 6'h01;
            end
        end
        if (pre_pulse) begin
            if (match_now) begin
                timer_count_nxt = 8'h00;
                if (post_cnt_r >= postscale_select) begin
                    post_cnt_nxt = 4'h0;
                    post_pulse = 1'b1;
                end else begin
                    post_cnt_nxt = post_cnt_r + 4'h1;
                end
            end else begin
                timer_count_nxt = timer_count_r + 8'h01;
            end
        end
        if (wr_count || wr_control) begin
            pre_cnt_nxt = 6'h00;
            post_cnt_nxt = 4'h0;
        end
        // software count write wins over counting
        // control write does not touch count
        if (wr_count) begin
            timer_count_nxt = wb_dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_r <= `COUNT_RST;
            timer_period_r <= `PERIOD_RST;
            timer_control_r <= `CONTROL_RST;
            pre_cnt_r <= 6'h00;
            post_cnt_r <= 4'h0;
            period_match_flag_r <= 1'b0;
            irq_mask_r <= 1'b0;
            period_match_o <= 1'b0;
        end else begin
            timer_count_r <= timer_count_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            post_cnt_r <= post_cnt_nxt;
            period_match_o <= pre_pulse & match_now;
            if (wr_period) begin
                timer_period_r <= wb_dat_i[7:0];
            end
            if (wr_control) begin
                timer_control_r <= wb_dat_i[6:0];
            end
            if (wr_mask) begin
                irq_mask_r <= wb_dat_i[0];
            end
            if (post_pulse) begin
                period_match_flag_r <= 1'b1;
            end else if (wr_status && wb_dat_i[0]) begin
                period_match_flag_r <= 1'b0;
            end
        end
    end

    assign irq_o = period_match_flag_r & irq_mask_r;

    // Read mux
    always @* begin
        rd_data = 32'h00000000;
        case (word_idx)
            `REG_COUNT: rd_data[7:0] = timer_count_r;
            `REG_PERIOD: rd_data[7:0] = timer_period_r;
            `REG_CONTROL: rd_data[6:0] = timer_control_r;
            `REG_STATUS: rd_data[0] = period_match_flag_r;
            `REG_MASK: rd_data[0] = irq_mask_r;
            default: rd_data = 32'h00000000;
        endcase
    end

    // Ack one cycle after request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            mapped_q <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_r <= req;
            mapped_q <= mapped;
            if (req) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule // period_match_timer_8bit

// file: sim/period_timer_chk.sv
`timescale 1ns/1ps
module period_timer_chk (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire irq_o,
    input wire period_match_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    chk_ack_next: assert property (s_take ##0 wb_adr_i[4:2] < 5 |=> wb_ack_o)
        else $error("no ack");
    chk_err_map: assert property (s_take ##0 wb_adr_i[4:2] > 4 |=> wb_err_o && !wb_ack_o)
        else $error("no err");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("stray ack");
    chk_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 0)
        else $error("upper bits set");
    // Ticks come every fourth clock, so matches cannot be closer
    chk_match_gap: assert property (period_match_o |=> !period_match_o [*3])
        else $error("match too soon");
    chk_irq_clear: assert property ($fell(irq_o) |-> $past(wb_stb_i && wb_we_i))
        else $error("irq fell alone");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !period_match_o)
        else $error("output after reset");
endmodule // period_timer_chk
bind period_match_timer_8bit period_timer_chk period_timer_chk_i (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .irq_o, .period_match_o);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, e;
    logic [4:0] adr = 0;
    logic [31:0] dat = 0, rd, d;
    wire [31:0] q;
    wire ack, err, irq, pm;
    int failures = 0, samples_checked = 0, n, t;
    // Address, write data, expected read
    logic [68:0] rows [4] = '{{5'h04, 32'h1ff5a, 32'h5a}, {5'h00, 32'h33, 32'h33},
        {5'h08, 32'hfb, 32'h7b}, {5'h10, 32'h1, 32'h1}};
    logic [3:0] post [3] = '{4'h0, 4'h3, 4'hf};
    period_match_timer_8bit period_match_timer_8bit_i (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err), .irq_o(irq), .period_match_o(pm));
    initial forever #5 clk_i = ~clk_i;
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, v};
        t = 0;
        do begin
            tick;
            t++;
        end while (!(ack | err) && t < 9);
        if (!(ack | err)) begin
            failures++;
            $display("CHECK FAILED bus answer expected 1 seen 0");
        end
        rd = q;
        e = err;
        @(posedge clk_i);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        bus(0, 5'h00, 0);
        chk("count", 0, rd);
        bus(0, 5'h04, 0);
        chk("period", 32'hff, rd);
        foreach (rows[i]) begin
            bus(1, rows[i][68:64], rows[i][63:32]);
            bus(0, rows[i][68:64], 0);
            chk("readback", rows[i][31:0], rd);
        end
        bus(1, 5'h08, 0);
        bus(0, 5'h00, 0);
        chk("count kept", 32'h33, rd);
        bus(0, 5'h1c, 0);
        chk("err", 1, e);
        $display("registers done");
        bus(1, 5'h04, 2);
        bus(1, 5'h00, 0);
        for (int p = 0; p < 4; p++) begin
            bus(1, 5'h08, 4 | p);
            do tick; while (pm !== 1);
            n = 0;
            do begin
                tick;
                n++;
            end while (pm !== 1);
            chk("gap", 12 << (2 * p), n);
        end
        bus(1, 5'h08, 0);
        bus(0, 5'h00, 0);
        d = rd;
        repeat (30) tick;
        bus(0, 5'h00, 0);
        chk("stopped", d, rd);
        $display("counting done");
        foreach (post[i]) begin
            bus(1, 5'h08, 0);
            bus(1, 5'h0c, 1);
            bus(1, 5'h00, 0);
            bus(1, 5'h08, {post[i], 3'h4});
            n = 0;
            t = 0;
            while (irq !== 1 && t < 999) begin
                tick;
                t++;
                n += pm;
            end
            repeat (2) begin
                tick;
                n += pm;
            end
            chk("pulses", post[i] + 32'h1, n);
        end
        bus(1, 5'h08, 0);
        bus(1, 5'h10, 0);
        chk("masked", 0, irq);
        bus(1, 5'h10, 1);
        chk("irq", 1, irq);
        bus(1, 5'h0c, 1);
        chk("cleared", 0, irq);
        $display("flags done");
        bus(1, 5'h04, 32'h5);
        bus(1, 5'h08, 32'h4);
        repeat (20) tick;
        rst_i <= 1;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        bus(0, 5'h00, 0);
        chk("count after reset", 0, rd);
        bus(0, 5'h04, 0);
        chk("period after reset", 32'hff, rd);
        bus(0, 5'h08, 0);
        chk("control after reset", 0, rd);
        $display("reset done");
        give_verdict;
    end
endmodule // tb_top
